// >>> pkg/asl_regs.svh
// Register map, field positions, codes and reset values of the axis software limit block
`ifndef ASL_REGS_SVH
`define ASL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ASL_ADDR_W        8
`define ASL_OFF_ENV       8'h00
`define ASL_OFF_PLIM      8'h04
`define ASL_OFF_NLIM      8'h08
`define ASL_OFF_CMD       8'h0c
`define ASL_OFF_STAT      8'h10
`define ASL_OFF_POS       8'h14
`define ASL_OFF_IRQS      8'h18
`define ASL_OFF_IRQM      8'h1c
`define ASL_OFF_SPEED     8'h20

// ----------------------------------------------------------------------------
// Compare setup fields
// ----------------------------------------------------------------------------
`define ASL_C1SEL_MSB     1
`define ASL_C1SEL_LSB     0
`define ASL_C1S_MSB       4
`define ASL_C1S_LSB       2
`define ASL_C1D_MSB       6
`define ASL_C1D_LSB       5
`define ASL_C2SEL_MSB     9
`define ASL_C2SEL_LSB     8
`define ASL_C2S_MSB       12
`define ASL_C2S_LSB       10
`define ASL_C2D_MSB       14
`define ASL_C2D_LSB       13
`define ASL_SEL_CMDPOS    2'h0
`define ASL_METHOD_SWLIM  3'h6
`define ASL_ACT_IMMED     2'h1
`define ASL_ACT_DECEL     2'h2

// ----------------------------------------------------------------------------
// Command register fields and codes
// ----------------------------------------------------------------------------
`define ASL_CMD_CODE_MSB  7
`define ASL_CMD_CODE_LSB  0
`define ASL_CMD_DIR_BIT   8
`define ASL_CMD_CSTART_P  8'h50
`define ASL_CMD_CSTART_N  8'h51
`define ASL_CMD_HSTART_A  8'h52
`define ASL_CMD_HSTART_B  8'h53
`define ASL_CMD_STOP      8'h49

// ----------------------------------------------------------------------------
// Speed register fields, status and interrupt bits, reset values
// ----------------------------------------------------------------------------
`define ASL_SPD_TGT_MSB   15
`define ASL_SPD_TGT_LSB   0
`define ASL_SPD_STR_MSB   31
`define ASL_SPD_STR_LSB   16
`define ASL_ST_RUN        0
`define ASL_ST_DECEL      1
`define ASL_ST_DIR        2
`define ASL_ST_PLIM       3
`define ASL_ST_NLIM       4
`define ASL_IRQ_W         4
`define ASL_IRQ_PSTOP     0
`define ASL_IRQ_NSTOP     1
`define ASL_IRQ_REFUSE    2
`define ASL_IRQ_IDLE      3
`define ASL_RST_ENV       32'h0000_0000
`define ASL_RST_SPEED     32'h03e8_0064
`define ASL_RST_WORD      32'h0000_0000

`endif

// >>> pkg/asl_pkg.sv
// Types shared by the axis software limit block
`default_nettype none
package asl_pkg;
  typedef logic [31:0] asl_word_t;
  typedef logic [15:0] asl_per_t;
  typedef enum logic [1:0] {
    asl_idle,
    asl_run,
    asl_decel
  } asl_state_t;
endpackage
`default_nettype wire

// >>> rtl/asl_limit_cmp.sv
// One software limit comparator against the command position counter
`timescale 1ns/1ps
`default_nettype none
`include "asl_regs.svh"
module asl_limit_cmp #(
  parameter int POS_W    = 32,
  parameter bit POSITIVE = 1'b1
) (
  input  wire logic signed [POS_W-1:0] pos_i,
  input  wire logic signed [POS_W-1:0] limit_i,
  input  wire logic        [2:0]       method_i,
  input  wire logic        [1:0]       sel_i,
  output logic                         active_o
);
  wire enabled;
  wire reached;

  // Only the command position counter may feed a software limit
  assign enabled  = (sel_i == `ASL_SEL_CMDPOS) && (method_i == `ASL_METHOD_SWLIM); // see RULE1
  // Combinational so that a stop lands before the next pulse at any rate
  assign reached  = POSITIVE ? (pos_i >= limit_i) : (pos_i <= limit_i); // see RULE10
  assign active_o = enabled && reached;
endmodule
`default_nettype wire

// >>> rtl/asl_top.sv
// Axis software limit block with APB registers, pulse output and interrupt
//
// Contract
// RULE1: both comparators watch command position counter
// RULE2: halt decided by comparator and travel direction
// RULE3: method 110 makes comparator one positive limit
// RULE4: method 110 makes comparator two negative limit
// RULE5: comparator one action: 01 immediate, 10 decelerate
// RULE6: comparator two action: 01 immediate, 10 decelerate
// RULE7: high-speed start with decel action decelerates
// RULE8: constant-speed start or other action stops immediately
// RULE9: start toward active limit refused, opposite allowed
// RULE10: positive at pos>=value, negative at pos<=value
`timescale 1ns/1ps
`default_nettype none
`include "asl_regs.svh"
module asl_top #(
  parameter int POS_W = 32
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire asl_pkg::asl_word_t   pwdata_i,
  output asl_pkg::asl_word_t        prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic                      pulse_o,
  output logic                      dir_o,
  output logic                      moving_o,
  output logic                      irq_o
);
  import asl_pkg::*;

  generate
    if (POS_W < 8 || POS_W > 32) begin : g_bad_width
      $error("asl_top: POS_W must lie between 8 and 32");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  asl_word_t               env_reg;
  logic signed [POS_W-1:0] plim_reg;
  logic signed [POS_W-1:0] nlim_reg;
  logic signed [POS_W-1:0] pos_reg;
  logic signed [POS_W-1:0] pos_next;
  asl_word_t               speed_reg;
  logic [`ASL_IRQ_W-1:0]   irq_sts_reg;
  logic [`ASL_IRQ_W-1:0]   irq_sts_next;
  logic [`ASL_IRQ_W-1:0]   irq_mask_reg;
  asl_state_t              state_reg;
  asl_state_t              state_next;
  logic                    dir_reg;
  logic                    hs_reg;
  asl_per_t                per_reg;
  asl_per_t                per_next;
  asl_per_t                tick_reg;
  logic                    pulse_reg;
  asl_word_t               prdata_reg;
  logic                    pslverr_reg;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  wire apb_setup = psel_i && !penable_i;
  wire apb_wr    = psel_i && penable_i && pwrite_i;
  wire sel_env   = (paddr_i == `ASL_OFF_ENV);
  wire sel_plim  = (paddr_i == `ASL_OFF_PLIM);
  wire sel_nlim  = (paddr_i == `ASL_OFF_NLIM);
  wire sel_cmd   = (paddr_i == `ASL_OFF_CMD);
  wire sel_stat  = (paddr_i == `ASL_OFF_STAT);
  wire sel_pos   = (paddr_i == `ASL_OFF_POS);
  wire sel_irqs  = (paddr_i == `ASL_OFF_IRQS);
  wire sel_irqm  = (paddr_i == `ASL_OFF_IRQM);
  wire sel_speed = (paddr_i == `ASL_OFF_SPEED);
  wire mapped    = sel_env || sel_plim || sel_nlim || sel_cmd || sel_stat ||
                   sel_pos || sel_irqs || sel_irqm || sel_speed;

  // --------------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------------
  logic pos_act;
  logic neg_act;

  asl_limit_cmp #(.POS_W(POS_W), .POSITIVE(1'b1)) u_cmp_pos (
    .pos_i    (pos_reg),
    .limit_i  (plim_reg),
    .method_i (env_reg[`ASL_C1S_MSB:`ASL_C1S_LSB]),   // see RULE3
    .sel_i    (env_reg[`ASL_C1SEL_MSB:`ASL_C1SEL_LSB]),
    .active_o (pos_act)
  );

  asl_limit_cmp #(.POS_W(POS_W), .POSITIVE(1'b0)) u_cmp_neg (
    .pos_i    (pos_reg),
    .limit_i  (nlim_reg),
    .method_i (env_reg[`ASL_C2S_MSB:`ASL_C2S_LSB]),   // see RULE4
    .sel_i    (env_reg[`ASL_C2SEL_MSB:`ASL_C2SEL_LSB]),
    .active_o (neg_act)
  );

  // --------------------------------------------------------------------------
  // Commands and limit response
  // --------------------------------------------------------------------------
  wire [7:0] code      = pwdata_i[`ASL_CMD_CODE_MSB:`ASL_CMD_CODE_LSB];
  wire       cmd_dir   = pwdata_i[`ASL_CMD_DIR_BIT];
  wire       cmd_wr    = apb_wr && sel_cmd;
  wire       is_hs     = (code == `ASL_CMD_HSTART_A) || (code == `ASL_CMD_HSTART_B);
  wire       is_cs     = (code == `ASL_CMD_CSTART_P) || (code == `ASL_CMD_CSTART_N);
  wire       is_start  = cmd_wr && (is_hs || is_cs) && (state_reg == asl_idle);
  wire       toward    = cmd_dir ? neg_act : pos_act;
  wire       start_ok  = is_start && !toward;                    // see RULE9
  wire       refused   = is_start && toward;                     // see RULE9
  wire       stop_cmd  = cmd_wr && (code == `ASL_CMD_STOP);
  wire [1:0] c1_act    = env_reg[`ASL_C1D_MSB:`ASL_C1D_LSB];
  wire [1:0] c2_act    = env_reg[`ASL_C2D_MSB:`ASL_C2D_LSB];
  // Positive travel is guarded by comparator one, negative by comparator two
  wire       hit_lim   = dir_reg ? neg_act : pos_act;            // see RULE2
  wire [1:0] hit_act   = dir_reg ? c2_act : c1_act;              // see RULE5, RULE6
  wire       decel_sel = hs_reg && (hit_act == `ASL_ACT_DECEL);  // see RULE7
  wire       lim_run   = (state_reg == asl_run) && hit_lim;
  wire       lim_decel = lim_run && decel_sel;                   // see RULE7
  // Immediate code, unused codes and constant-speed runs all stop at once
  wire       lim_immed = lim_run && !decel_sel;                  // see RULE8
  wire       moving    = (state_reg != asl_idle);
  wire       halt_now  = lim_immed || (moving && stop_cmd);
  wire [16:0] tick_inc = {1'b0, tick_reg} + 17'h0_0001;
  wire       tick_wrap = (tick_inc >= {1'b0, per_reg});
  wire       fire      = moving && !halt_now && tick_wrap;
  wire asl_per_t tgt_per = speed_reg[`ASL_SPD_TGT_MSB:`ASL_SPD_TGT_LSB];
  wire asl_per_t str_per = speed_reg[`ASL_SPD_STR_MSB:`ASL_SPD_STR_LSB];
  wire       decel_end = (state_reg == asl_decel) && fire && (per_reg >= str_per);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      asl_idle: begin
        if (start_ok) begin
          state_next = asl_run;
        end
      end
      asl_run: begin
        if (halt_now) begin
          state_next = asl_idle;
        end else if (lim_decel) begin
          state_next = asl_decel;
        end
      end
      asl_decel: begin
        if (stop_cmd || decel_end) begin
          state_next = asl_idle;
        end
      end
      default: begin
        state_next = asl_idle;
      end
    endcase
  end

  // Speed ramp: high-speed runs start slow and step toward the target
  always_comb begin
    per_next = per_reg;
    if (start_ok) begin
      per_next = (is_hs && str_per > tgt_per) ? str_per : tgt_per;
    end else if (fire && state_reg == asl_decel) begin
      per_next = per_reg + 16'h0001;
    end else if (fire && hs_reg && per_reg > tgt_per) begin
      per_next = per_reg - 16'h0001;
    end
  end

  // Position follows every issued pulse; software may preset it only at rest
  always_comb begin
    pos_next = pos_reg;
    if (fire) begin
      pos_next = dir_reg ? pos_reg - 1'b1 : pos_reg + 1'b1;     // see RULE1
    end else if (apb_wr && sel_pos && !moving) begin
      pos_next = pwdata_i[POS_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status: an event in the clearing cycle survives
  // --------------------------------------------------------------------------
  wire [`ASL_IRQ_W-1:0] irq_ev;
  wire [`ASL_IRQ_W-1:0] irq_clr;
  assign irq_ev[`ASL_IRQ_PSTOP]  = lim_run && !dir_reg;
  assign irq_ev[`ASL_IRQ_NSTOP]  = lim_run && dir_reg;
  assign irq_ev[`ASL_IRQ_REFUSE] = refused;
  assign irq_ev[`ASL_IRQ_IDLE]   = moving && (state_next == asl_idle);
  assign irq_clr = (apb_wr && sel_irqs) ? pwdata_i[`ASL_IRQ_W-1:0] : '0;
  assign irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_ev;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  wire asl_word_t stat_word = asl_word_t'({neg_act, pos_act, dir_reg,
                              (state_reg == asl_decel), moving});
  wire asl_word_t rd_data =
    sel_plim  ? asl_word_t'($unsigned(plim_reg)) :
    sel_nlim  ? asl_word_t'($unsigned(nlim_reg)) :
    sel_stat  ? stat_word :
    sel_pos   ? asl_word_t'($unsigned(pos_reg)) :
    sel_irqs  ? asl_word_t'(irq_sts_reg) :
    sel_irqm  ? asl_word_t'(irq_mask_reg) :
    sel_speed ? speed_reg : `ASL_RST_WORD;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      env_reg   <= `ASL_RST_ENV;
      plim_reg  <= '0;
      nlim_reg  <= '0;
      speed_reg <= `ASL_RST_SPEED;
      irq_mask_reg <= '0;
    end else if (apb_wr) begin
      if (sel_env) env_reg <= pwdata_i;
      if (sel_plim) plim_reg <= pwdata_i[POS_W-1:0];
      if (sel_nlim) nlim_reg <= pwdata_i[POS_W-1:0];
      if (sel_speed) speed_reg <= pwdata_i;
      if (sel_irqm) irq_mask_reg <= pwdata_i[`ASL_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= asl_idle;
      dir_reg     <= 1'b0;
      hs_reg      <= 1'b0;
      per_reg     <= '0;
      tick_reg    <= '0;
      pulse_reg   <= 1'b0;
      pos_reg     <= '0;
      irq_sts_reg <= '0;
    end else begin
      state_reg   <= state_next;
      per_reg     <= per_next;
      pos_reg     <= pos_next;
      pulse_reg   <= fire;
      irq_sts_reg <= irq_sts_next;
      tick_reg    <= (!moving || start_ok || tick_wrap) ? '0 : tick_inc[15:0];
      if (start_ok) begin
        dir_reg <= cmd_dir;
        hs_reg  <= is_hs;
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg  <= `ASL_RST_WORD;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= pwrite_i ? `ASL_RST_WORD : rd_data;
      pslverr_reg <= !mapped;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg;
  assign pready_o  = 1'b1;
  assign pulse_o   = pulse_reg;
  assign dir_o     = dir_reg;
  assign moving_o  = moving;
  assign irq_o     = |(irq_sts_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  pulse_count_a: assert property (pulse_o |-> pos_reg == ($past(dir_reg) ? // see RULE1
      $past(pos_reg) - 1'b1 : $past(pos_reg) + 1'b1))
    else $error("position did not follow pulse");

  dir_guard_a: assert property ((state_reg == asl_run && pos_act && dir_reg && !neg_act) // see RULE2
      |=> state_reg == asl_run || $past(stop_cmd))
    else $error("positive limit stopped negative travel");

  pos_method_a: assert property ((pos_act && env_reg[`ASL_C1S_MSB:`ASL_C1S_LSB] != `ASL_METHOD_SWLIM) // see RULE3
      |-> 1'b0)
    else $error("positive limit active without method 110");

  neg_method_a: assert property ((neg_act && env_reg[`ASL_C2S_MSB:`ASL_C2S_LSB] != `ASL_METHOD_SWLIM) // see RULE4
      |-> 1'b0)
    else $error("negative limit active without method 110");

  pos_immed_a: assert property ((state_reg == asl_run && !dir_reg && pos_act && // see RULE5
      c1_act == `ASL_ACT_IMMED) |=> state_reg == asl_idle && !pulse_o ##1 !pulse_o)
    else $error("positive immediate stop failed");

  neg_decel_a: assert property ((state_reg == asl_run && dir_reg && neg_act && hs_reg && // see RULE6
      c2_act == `ASL_ACT_DECEL) |=> state_reg == asl_decel || $past(stop_cmd))
    else $error("negative decelerating stop failed");

  hs_decel_a: assert property ((state_reg == asl_decel) |-> hs_reg) // see RULE7
    else $error("deceleration outside high-speed run");

  const_stop_a: assert property ((state_reg == asl_run && !hs_reg && hit_lim) // see RULE8
      |=> state_reg == asl_idle ##1 !pulse_o)
    else $error("constant-speed run not stopped at once");

  start_refuse_a: assert property (refused |=> state_reg == asl_idle && // see RULE9
      irq_sts_reg[`ASL_IRQ_REFUSE])
    else $error("start toward active limit not refused");

  start_opposite_a: assert property ((is_start && cmd_dir && pos_act && !neg_act) // see RULE9
      |=> state_reg == asl_run && dir_reg)
    else $error("start away from limit refused");

  pos_thresh_a: assert property (pos_act |-> pos_reg >= plim_reg) // see RULE10
    else $error("positive limit below threshold");

  cover_refuse_c: cover property (refused);
  cover_decel_c: cover property (lim_decel ##[1:1000] state_reg == asl_idle);
  cover_immed_c: cover property (lim_immed);
  cover_opposite_c: cover property (start_ok && (pos_act || neg_act));
endmodule
`default_nettype wire

// >>> testbench/asl_drv_model.sv
// Motor driver model that turns command pulses into a signed step count
`timescale 1ns/1ps
`default_nettype none
module asl_drv_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        pulse_i,
  input  wire logic        dir_i,
  output logic signed [31:0] steps_o
);
  // ---------------------------------------------------------------------------
  // Step counting
  // ---------------------------------------------------------------------------
  // Direction is sampled with each pulse, as a real driver latches it on the step edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      steps_o <= 32'sh0;
    end else if (pulse_i === 1'b1) begin
      steps_o <= (dir_i === 1'b1) ? steps_o - 32'sh1 : steps_o + 32'sh1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_axis_software_limit.sv
// Self-checking testbench of the axis software limit block
`timescale 1ns/1ps
`default_nettype none
`include "asl_regs.svh"
module test_axis_software_limit;
  import asl_pkg::*;
  logic               clock_i;
  logic               rst_n_i;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  asl_word_t          pwdata;
  asl_word_t          prdata;
  logic               pready;
  logic               pslverr;
  logic               pulse;
  logic               dir;
  logic               moving;
  logic               irq;
  logic signed [31:0] steps;
  int                 bad_count;
  int                 samples_checked;

  asl_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pulse_o(pulse), .dir_o(dir), .moving_o(moving), .irq_o(irq));
  asl_drv_model i_drv (.clock_i(clock_i), .rst_n_i(rst_n_i), .pulse_i(pulse), .dir_i(dir), .steps_o(steps));

  // ---------------------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------------------
  task automatic chk_w(input string name, input asl_word_t exp, input asl_word_t got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_b(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input asl_word_t d, output asl_word_t r, output logic e);
    int n;
    @(posedge clock_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    chk_b("pready", 1'b1, pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input asl_word_t d);
    asl_word_t r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output asl_word_t r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (moving === 1'b1 && n < 5000);
    chk_b("idle reached", 1'b0, moving);
    repeat (2) @(posedge clock_i);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    asl_word_t r;
    logic e;
    rd(`ASL_OFF_SPEED, r); chk_w("speed", `ASL_RST_SPEED, r);
    rd(`ASL_OFF_STAT, r);  chk_w("status", 32'h0000_0000, r);
    rd(`ASL_OFF_POS, r);   chk_w("position", 32'h0000_0000, r);
    rd(`ASL_OFF_ENV, r);   chk_w("setup", 32'h0000_0000, r);
    apb(1'b0, 8'h24, 32'h0000_0000, r, e);
    chk_b("unmapped err", 1'b1, e);
    chk_w("unmapped data", 32'h0000_0000, r);
  endtask

  task automatic t_pos_immediate;
    asl_word_t r;
    wr(`ASL_OFF_SPEED, 32'h0004_0002);
    wr(`ASL_OFF_ENV, 32'h0000_3838);
    wr(`ASL_OFF_PLIM, 32'h0000_0005);
    wr(`ASL_OFF_NLIM, 32'hffff_fffb);
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_CSTART_P});
    wait_idle();
    rd(`ASL_OFF_POS, r); chk_w("position at plus limit", 32'h0000_0005, r);
    chk_w("driver steps", 32'h0000_0005, steps);
    rd(`ASL_OFF_IRQS, r); chk_w("stop events", 32'h0000_0009, r & 32'h0000_000f);
  endtask

  task automatic t_irq;
    asl_word_t r;
    chk_b("irq masked", 1'b0, irq);
    wr(`ASL_OFF_IRQM, 32'h0000_0001);
    @(posedge clock_i);
    chk_b("irq unmasked", 1'b1, irq);
    wr(`ASL_OFF_IRQS, 32'h0000_000f);
    @(posedge clock_i);
    chk_b("irq cleared", 1'b0, irq);
    rd(`ASL_OFF_IRQS, r); chk_w("events cleared", 32'h0000_0000, r);
  endtask

  task automatic t_refuse_then_reverse;
    asl_word_t r;
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_CSTART_P});
    @(posedge clock_i);
    chk_b("refused start", 1'b0, moving);
    rd(`ASL_OFF_IRQS, r); chk_w("refuse event", 32'h0000_0004, r & 32'h0000_0004);
    wr(`ASL_OFF_IRQS, 32'h0000_000f);
    wr(`ASL_OFF_CMD, {23'h0, 1'b1, `ASL_CMD_CSTART_N});
    @(posedge clock_i);
    chk_b("reverse start", 1'b1, moving);
    chk_b("reverse dir", 1'b1, dir);
    wait_idle();
    rd(`ASL_OFF_POS, r); chk_w("position at minus limit", 32'hffff_fffb, r);
    chk_w("driver steps back", 32'hffff_fffb, steps);
    rd(`ASL_OFF_IRQS, r); chk_w("minus stop event", 32'h0000_000a, r & 32'h0000_000f);
  endtask

  task automatic t_decel_then_constant;
    asl_word_t r;
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    wr(`ASL_OFF_ENV, 32'h0000_5858);
    wr(`ASL_OFF_PLIM, 32'h0000_0003);
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_HSTART_A});
    do begin
      rd(`ASL_OFF_STAT, r);
      if (r[`ASL_ST_DECEL] === 1'b1) seen = 1'b1;
      n++;
    end while (r[`ASL_ST_RUN] === 1'b1 && n < 500);
    chk_b("ramp ended", 1'b0, r[`ASL_ST_RUN]);
    chk_b("ramp down seen", 1'b1, seen);
    rd(`ASL_OFF_POS, r); chk_b("travel past limit", 1'b1, $signed(r) > 3);
    wr(`ASL_OFF_POS, 32'h0000_0000);
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_CSTART_P});
    wait_idle();
    rd(`ASL_OFF_POS, r); chk_w("constant speed halt", 32'h0000_0003, r);
    wr(`ASL_OFF_ENV, 32'h0000_5800);
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_HSTART_B});
    repeat (30) @(posedge clock_i);
    chk_b("disabled limit runs on", 1'b1, moving);
    wr(`ASL_OFF_CMD, {24'h0, `ASL_CMD_STOP});
    wait_idle();
    // Negative high-speed run into comparator two with decelerating action
    wr(`ASL_OFF_CMD, {23'h0, 1'b1, `ASL_CMD_HSTART_B});
    wait_idle();
    rd(`ASL_OFF_POS, r); chk_b("minus ramp past limit", 1'b1, $signed(r) < -5);
    rd(`ASL_OFF_IRQS, r); chk_w("minus ramp event", 32'h0000_0002, r & 32'h0000_0002);
  endtask

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    repeat (50000) @(posedge clock_i);
    bad_count++;
    end_sim();
  end

  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_pos_immediate();
    t_irq();
    t_refuse_then_reverse();
    t_decel_then_constant();
    end_sim();
  end
endmodule
`default_nettype wire
